// ---- dv/dmrc_ctl_model.sv ----
// controller model: command pins, link clock runs only within a frame
`timescale 1ns/1ps
module dmrc_ctl_model (
  input wire clk_sys,
  output reg linkClk = 1'b0,
  output reg cmdValid = 1'b0,
  output reg isModeWrite = 1'b0,
  output reg isRefresh = 1'b0,
  output reg [19:0] addrIn = 20'h00000,
  output reg [3:0] bankIn = 4'h0
);
  // one 80 ns link period per address part
  task part(input [19:0] a);
    begin
      addrIn <= a;
      repeat (4) @(posedge clk_sys);
      linkClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      linkClk <= 1'b0;
    end
  endtask
  // callers space frames so bank and calibration quiet times hold
  task send(input mw, input rf, input [19:0] a, input [3:0] b, input two, input [19:0] a2);
    begin
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      isModeWrite <= mw;
      isRefresh <= rf;
      bankIn <= b;
      part(a);
      if (two)
        part(a2);
      repeat (2) @(posedge clk_sys);
      cmdValid <= 1'b0;
      // released pins must not keep the last value
      addrIn <= ~addrIn;
      bankIn <= ~bankIn;
    end
  endtask
endmodule

// ---- dv/dmrc_mode_regs_bench.sv ----
// bench: mode writes, calibration, refresh and termination
`timescale 1ns/1ps
`include "dmrc_map.vh"
module dmrc_mode_regs_bench;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg readDriving = 1'b0;
  reg odtReqIn = 1'b0;
  wire linkClk, cmdValid, isModeWrite, isRefresh, dllEnable_ff, muxAddrMode_ff, calDie;
  wire calShortSel_ff, calStart_ff, multiBankRefresh_ff, calBusy, dqOdtOn_ff;
  wire ctlOdtOn_ff, refreshPulse_ff, addrValid_ff;
  wire [19:0] addrIn, fullAddr_ff;
  wire [3:0] bankIn, rowCycleCnt_ff, dataLatency_ff, cmdBank_ff;
  wire [2:0] odtValue_ff;
  wire [1:0] driveSel_ff, dualDieOdt_ff;
  wire [15:0] refreshBanks_ff;
  integer failures = 0;
  integer n_checks = 0;
  integer busyCnt = 0;
  integer i;
  integer nValid = 0;
  integer nRefresh = 0;
  dmrc_mode_regs #(.LONG_CYC(8), .SHORT_CYC(4)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .linkClk(linkClk),
    .cmdValid(cmdValid),
    .isModeWrite(isModeWrite),
    .isRefresh(isRefresh),
    .addrIn(addrIn),
    .bankIn(bankIn),
    .readDriving(readDriving),
    .odtReqIn(odtReqIn),
    .rowCycleCnt_ff(rowCycleCnt_ff),
    .dataLatency_ff(dataLatency_ff),
    .dllEnable_ff(dllEnable_ff),
    .muxAddrMode_ff(muxAddrMode_ff),
    .driveSel_ff(driveSel_ff),
    .odtValue_ff(odtValue_ff),
    .calShortSel_ff(calShortSel_ff),
    .calStart_ff(calStart_ff),
    .multiBankRefresh_ff(multiBankRefresh_ff),
    .dualDieOdt_ff(dualDieOdt_ff),
    .calBusy(calBusy),
    .calDie(calDie),
    .dqOdtOn_ff(dqOdtOn_ff),
    .ctlOdtOn_ff(ctlOdtOn_ff),
    .refreshBanks_ff(refreshBanks_ff),
    .refreshPulse_ff(refreshPulse_ff),
    .fullAddr_ff(fullAddr_ff),
    .cmdBank_ff(cmdBank_ff),
    .addrValid_ff(addrValid_ff)
  );
  dmrc_ctl_model ctl (
    .clk_sys(clk_sys),
    .linkClk(linkClk),
    .cmdValid(cmdValid),
    .isModeWrite(isModeWrite),
    .isRefresh(isRefresh),
    .addrIn(addrIn),
    .bankIn(bankIn)
  );
  // pulses seen: one per non-write command, one per refresh
  always @(posedge clk_sys)
  begin
    nValid <= nValid + addrValid_ff;
    nRefresh <= nRefresh + refreshPulse_ff;
  end
  always #5 clk_sys = ~clk_sys;
  // busy cycles of the latest calibration; a new command restarts the count
  always @(posedge clk_sys)
    busyCnt <= calBusy ? busyCnt + 1 : (cmdValid ? 0 : busyCnt);
  task chk(input [19:0] seen, input [19:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    failures = failures + 1;
    stop_test;
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk(dllEnable_ff, 1'b1);
    chk(driveSel_ff, `DMRC_DRV_44);
    ctl.send(1'b1, 1'b0, 20'h0037A, 4'h0, 1'b0, 20'h00000);
    chk(rowCycleCnt_ff, 4'hA);
    chk(dataLatency_ff, 4'h7);
    chk(muxAddrMode_ff, 1'b1);
    ctl.send(1'b0, 1'b0, 20'h0055A, 4'h9, 1'b1, 20'h001C3);
    chk(fullAddr_ff, 20'hE1D5A);
    chk(cmdBank_ff, 4'h9);
    // loop off, row count equal to latency, in two parts
    ctl.send(1'b1, 1'b0, 20'h00077, 4'h0, 1'b1, 20'h00000);
    chk(dllEnable_ff, 1'b0);
    chk(muxAddrMode_ff, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      ctl.send(1'b1, 1'b0, i ? 20'h00080 : 20'h001D5, 4'h1, 1'b0, 20'h00000);
      chk(calShortSel_ff, !i);
      chk(driveSel_ff, i ? `DMRC_DRV_44 : `DMRC_DRV_58);
      chk(multiBankRefresh_ff, !i);
      repeat (40) if (calStart_ff) @(posedge clk_sys);
      chk(calStart_ff, 1'b0);
      chk(busyCnt >= (i ? 16 : 8) && busyCnt <= (i ? 20 : 12), 1'b1);
      ctl.send(1'b0, 1'b1, 20'h08421, 4'h5, 1'b0, 20'h00000);
      chk(refreshBanks_ff, i ? 16'h0020 : 16'h8421);
    end
    ctl.send(1'b1, 1'b0, 20'h00014, 4'h1, 1'b0, 20'h00000);
    chk(odtValue_ff, 3'h5);
    odtReqIn <= 1'b1;
    readDriving <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(dqOdtOn_ff, 1'b0);
    chk(ctlOdtOn_ff, 1'b1);
    readDriving <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(dqOdtOn_ff, 1'b1);
    ctl.send(1'b1, 1'b0, 20'h00300, 4'h2, 1'b0, 20'h00000);
    chk(dualDieOdt_ff, 2'h3);
    chk(nValid, 3);
    chk(nRefresh, 2);
    stop_test;
  end
endmodule

// ---- dv/dmrc_mode_regs_sva.sv ----
// assertion checker for the mode register bank
`timescale 1ns/1ps
module dmrc_mode_regs_sva #(
  parameter LONG_CYC = 8
)(
  input wire clk_sys,
  input wire rst,
  input wire cmdValid,
  input wire isModeWrite,
  input wire readDriving,
  input wire odtReqIn,
  input wire [3:0] rowCycleCnt_ff,
  input wire [2:0] odtValue_ff,
  input wire calStart_ff,
  input wire calBusy,
  input wire calDie,
  input wire dqOdtOn_ff,
  input wire refreshPulse_ff
);
  // two dies of the long kind plus start and hand-over slack
  localparam int CAL_MAX = 2 * LONG_CYC + 8;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_rc_cause: assert property (
    $changed(rowCycleCnt_ff) |-> $past(cmdValid && isModeWrite))
    else $error("row count moved without a mode write");
  a_cal_starts: assert property (
    $rose(calStart_ff) |=> calBusy)
    else $error("calibration did not start");
  a_cal_ends: assert property (
    calStart_ff |-> ##[1:CAL_MAX] !calStart_ff)
    else $error("start bit never cleared");
  a_die_first: assert property (
    $rose(calBusy) |-> !calDie)
    else $error("calibration began on the second die");
  a_die_last: assert property (
    $fell(calBusy) |-> $past(calDie))
    else $error("calibration ended before the second die");
  a_odt_off: assert property (
    readDriving && odtReqIn && odtValue_ff != 3'h0 |-> ##[1:2] !dqOdtOn_ff)
    else $error("data termination on while driving");
  a_odt_back: assert property (
    $fell(readDriving) && odtReqIn && odtValue_ff != 3'h0 |-> ##[1:3] dqOdtOn_ff)
    else $error("data termination not restored");
  a_ref_pulse: assert property (
    refreshPulse_ff |=> !refreshPulse_ff)
    else $error("refresh pulse too long");
endmodule
bind dmrc_mode_regs dmrc_mode_regs_sva #(.LONG_CYC(LONG_CYC)) chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .cmdValid(cmdValid),
  .isModeWrite(isModeWrite),
  .readDriving(readDriving),
  .odtReqIn(odtReqIn),
  .rowCycleCnt_ff(rowCycleCnt_ff),
  .odtValue_ff(odtValue_ff),
  .calStart_ff(calStart_ff),
  .calBusy(calBusy),
  .calDie(calDie),
  .dqOdtOn_ff(dqOdtOn_ff),
  .refreshPulse_ff(refreshPulse_ff)
);

// ---- src/dmrc_cal_seq.v ----
// impedance calibration sequencer, one or two dies in turn
`timescale 1ns/1ps
`include "dmrc_map.vh"
module dmrc_cal_seq #(
  parameter LONG_CYC = `DMRC_CAL_LONG_CYC,
  parameter SHORT_CYC = `DMRC_CAL_SHORT_CYC
)(
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire useShort,
  input wire twoDies,
  output reg busy_ff,
  output reg dieSel_ff,
  output reg done_ff
);
  reg [15:0] cnt_ff;
  wire [15:0] len = useShort ? SHORT_CYC[15:0] : LONG_CYC[15:0];
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      dieSel_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      done_ff <= 1'b0;
      if (!busy_ff)
      begin
        if (start)
        begin
          busy_ff <= 1'b1;
          dieSel_ff <= 1'b0;
          cnt_ff <= len - 16'h0001;
        end
      end
      else if (cnt_ff != 16'h0000)
        cnt_ff <= cnt_ff - 16'h0001;
      else if (twoDies && !dieSel_ff)
      begin
        // wide config: second die after the first, doubling duration
        dieSel_ff <= 1'b1;
        cnt_ff <= len - 16'h0001;
      end
      else
      begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end
endmodule

// ---- src/dmrc_map.vh ----
// mode register map, field positions and timing constants
`ifndef DMRC_MAP_VH
`define DMRC_MAP_VH
`define DMRC_BA_MR0 2'h0
`define DMRC_BA_MR1 2'h1
`define DMRC_BA_MR2 2'h2
`define DMRC_RC_LSB 0
`define DMRC_LAT_LSB 4
`define DMRC_DLL_BIT 8
`define DMRC_MUX_BIT 9
`define DMRC_DRV_LSB 0
`define DMRC_ODT_LSB 2
`define DMRC_CALSEL_BIT 6
`define DMRC_CALGO_BIT 7
`define DMRC_REFMB_BIT 8
`define DMRC_DDPODT_LSB 8
`define DMRC_MR0_RST 20'h00100
`define DMRC_MR1_RST 20'h00000
`define DMRC_MR2_RST 20'h00000
`define DMRC_DRV_44 2'h0
`define DMRC_DRV_58 2'h1
`define DMRC_CAL_LONG_CYC 512
`define DMRC_CAL_SHORT_CYC 128
`endif

// ---- src/dmrc_mode_regs.v ----
// mode register bank: capture, decode and effects of three mode registers
//
// Overview of operation
// - row cycle count from first register bits 3:0
// - bits 7:4 give shared read/write latency
// - bit 8 enables the delay-locked loop
// - bit 9 selects two-part multiplexed address
// - multiplexed uses 11 balls, broadside 20
// - command and bank ride the first part
// - bits 1:0 pick drive, 44.3 at reset
// - bits 4:2 select termination value
// - data termination off while driving reads
// - bit 6 picks long or short calibration
// - bit 7 starts calibration, clears itself
// - wide config calibrates both dies sequentially
// - second register bit 8 selects refresh protocol
// - multibank refresh masks banks by address
// - third register bits 9:8 set dual-die termination
`timescale 1ns/1ps
`include "dmrc_map.vh"
module dmrc_mode_regs #(
  parameter ADDR_W = 20,
  parameter MUX_W = 11,
  parameter LONG_CYC = `DMRC_CAL_LONG_CYC,
  parameter SHORT_CYC = `DMRC_CAL_SHORT_CYC,
  parameter WIDE_CFG = 1
)(
  input wire clk_sys,
  input wire rst,
  input wire linkClk,
  input wire cmdValid,
  input wire isModeWrite,
  input wire isRefresh,
  input wire [ADDR_W-1:0] addrIn,
  input wire [3:0] bankIn,
  input wire readDriving,
  input wire odtReqIn,
  output reg [3:0] rowCycleCnt_ff,
  output reg [3:0] dataLatency_ff,
  output reg dllEnable_ff,
  output reg muxAddrMode_ff,
  output reg [1:0] driveSel_ff,
  output reg [2:0] odtValue_ff,
  output reg calShortSel_ff,
  output reg calStart_ff,
  output reg multiBankRefresh_ff,
  output reg [1:0] dualDieOdt_ff,
  output wire calBusy,
  output wire calDie,
  output reg dqOdtOn_ff,
  output reg ctlOdtOn_ff,
  output reg [15:0] refreshBanks_ff,
  output reg refreshPulse_ff,
  output reg [ADDR_W-1:0] fullAddr_ff,
  output reg [3:0] cmdBank_ff,
  output reg addrValid_ff
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SECOND = 1'b1;
  // reset words of the three registers; fields other than drive are cut from them by position
  localparam [19:0] MR0_RST = `DMRC_MR0_RST;
  localparam [19:0] MR1_RST = `DMRC_MR1_RST;
  localparam [19:0] MR2_RST = `DMRC_MR2_RST;
  // link clock crosses in: three stages, edge when second and third agree
  reg [2:0] clkSync_ff;
  reg clkStable_ff;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      clkSync_ff <= 3'h0;
      clkStable_ff <= 1'b0;
    end
    else
    begin
      clkSync_ff <= {clkSync_ff[1:0], linkClk};
      if (clkSync_ff[2] == clkSync_ff[1])
        clkStable_ff <= clkSync_ff[2];
    end
  end
  wire linkRise = (clkSync_ff[2] == clkSync_ff[1]) && clkSync_ff[2] && !clkStable_ff;

  // command pins cross in the same way, bit by bit, before the link edge uses them
  // a bit moving close to the edge is not counted until two stages agree
  localparam PIN_W = ADDR_W + 7;
  wire [PIN_W-1:0] pinRaw = {cmdValid, isModeWrite, isRefresh, bankIn, addrIn};
  wire [PIN_W-1:0] pinSt;
  genvar p;
  generate
    for (p = 0; p < PIN_W; p = p + 1)
    begin : g_pin
      reg [2:0] stage_ff;
      reg stable_ff;
      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          stage_ff <= 3'h0;
          stable_ff <= 1'b0;
        end
        else
        begin
          stage_ff <= {stage_ff[1:0], pinRaw[p]};
          if (stage_ff[2] == stage_ff[1])
            stable_ff <= stage_ff[2];
        end
      end
      assign pinSt[p] = stable_ff;
    end
  endgenerate
  wire cmdValidS = pinSt[ADDR_W+6];
  wire modeWriteS = pinSt[ADDR_W+5];
  wire refreshS = pinSt[ADDR_W+4];
  wire [3:0] bankS = pinSt[ADDR_W+3:ADDR_W];
  wire [ADDR_W-1:0] addrS = pinSt[ADDR_W-1:0];

  // pins sampled on link rising edge; controller holds them across the edge
  reg state_ff;
  reg nxt_state;
  reg heldWrite_ff;
  reg heldRefresh_ff;
  reg [ADDR_W-1:0] firstPart_ff;
  reg cmdWrite;
  reg cmdRefresh;
  reg [ADDR_W-1:0] cmdAddr;
  reg cmdFire;
  // second part fills the upper bits; mapping of balls is left to the core
  always @*
  begin
    nxt_state = state_ff;
    cmdFire = 1'b0;
    cmdWrite = modeWriteS;
    cmdRefresh = refreshS;
    cmdAddr = addrS;
    if (linkRise)
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (cmdValidS && muxAddrMode_ff)
            nxt_state = ST_SECOND;
          else if (cmdValidS)
            cmdFire = 1'b1;
        end
        ST_SECOND:
        begin
          nxt_state = ST_IDLE;
          cmdFire = 1'b1;
          cmdWrite = heldWrite_ff;
          cmdRefresh = heldRefresh_ff;
          // only low balls carry address in the two-part form
          cmdAddr = {addrS[ADDR_W-MUX_W-1:0], firstPart_ff[MUX_W-1:0]};
        end
        default:
          nxt_state = ST_IDLE;
      endcase
    end
  end
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      heldWrite_ff <= 1'b0;
      heldRefresh_ff <= 1'b0;
      firstPart_ff <= {ADDR_W{1'b0}};
      cmdBank_ff <= 4'h0;
      fullAddr_ff <= {ADDR_W{1'b0}};
      addrValid_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      addrValid_ff <= cmdFire && !cmdWrite;
      if (linkRise && state_ff == ST_IDLE && cmdValidS)
      begin
        // command and bank are taken only with the first part
        heldWrite_ff <= modeWriteS;
        heldRefresh_ff <= refreshS;
        firstPart_ff <= addrS;
        cmdBank_ff <= bankS;
      end
      if (cmdFire)
        fullAddr_ff <= cmdAddr;
    end
  end
  // bank of the command firing now: the pins, or the one held from the first part
  wire [3:0] bankNow = (state_ff == ST_SECOND) ? cmdBank_ff : bankS;
  wire [1:0] selNow = bankNow[1:0];
  wire wrFire = cmdFire && cmdWrite;
  wire calDone;
  // register writes; start bit self-clears once the sequence is done
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rowCycleCnt_ff <= MR0_RST[`DMRC_RC_LSB+3:`DMRC_RC_LSB];
      dataLatency_ff <= MR0_RST[`DMRC_LAT_LSB+3:`DMRC_LAT_LSB];
      dllEnable_ff <= MR0_RST[`DMRC_DLL_BIT];
      muxAddrMode_ff <= MR0_RST[`DMRC_MUX_BIT];
      driveSel_ff <= `DMRC_DRV_44;
      odtValue_ff <= MR1_RST[`DMRC_ODT_LSB+2:`DMRC_ODT_LSB];
      calShortSel_ff <= MR1_RST[`DMRC_CALSEL_BIT];
      calStart_ff <= MR1_RST[`DMRC_CALGO_BIT];
      multiBankRefresh_ff <= MR1_RST[`DMRC_REFMB_BIT];
      dualDieOdt_ff <= MR2_RST[`DMRC_DDPODT_LSB+1:`DMRC_DDPODT_LSB];
    end
    else
    begin
      if (calDone)
        calStart_ff <= 1'b0;
      if (wrFire && selNow == `DMRC_BA_MR0)
      begin
        rowCycleCnt_ff <= cmdAddr[`DMRC_RC_LSB+3:`DMRC_RC_LSB];
        dataLatency_ff <= cmdAddr[`DMRC_LAT_LSB+3:`DMRC_LAT_LSB];
        dllEnable_ff <= cmdAddr[`DMRC_DLL_BIT];
        muxAddrMode_ff <= cmdAddr[`DMRC_MUX_BIT];
      end
      if (wrFire && selNow == `DMRC_BA_MR1)
      begin
        driveSel_ff <= cmdAddr[`DMRC_DRV_LSB+1:`DMRC_DRV_LSB];
        odtValue_ff <= cmdAddr[`DMRC_ODT_LSB+2:`DMRC_ODT_LSB];
        calShortSel_ff <= cmdAddr[`DMRC_CALSEL_BIT];
        multiBankRefresh_ff <= cmdAddr[`DMRC_REFMB_BIT];
        // a write during calibration cannot cancel it
        if (!calBusy)
          calStart_ff <= cmdAddr[`DMRC_CALGO_BIT];
      end
      if (wrFire && selNow == `DMRC_BA_MR2)
        dualDieOdt_ff <= cmdAddr[`DMRC_DDPODT_LSB+1:`DMRC_DDPODT_LSB];
    end
  end
  reg calStartSeen_ff;
  always @(posedge clk_sys)
  begin
    if (rst)
      calStartSeen_ff <= 1'b0;
    // a start written in the done cycle wins and must launch a fresh run
    else if (calDone)
      calStartSeen_ff <= 1'b0;
    else
      calStartSeen_ff <= calStart_ff;
  end
  dmrc_cal_seq #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_cal (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(calStart_ff && !calStartSeen_ff),
    .useShort(calShortSel_ff),
    .twoDies(WIDE_CFG != 0),
    .busy_ff(calBusy),
    .dieSel_ff(calDie),
    .done_ff(calDone)
  );

  // refresh: single bank by bank address, or multibank mask from address
  wire refFire = cmdFire && cmdRefresh && !cmdWrite;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      refreshBanks_ff <= 16'h0000;
      refreshPulse_ff <= 1'b0;
    end
    else
    begin
      refreshPulse_ff <= refFire;
      if (refFire)
      begin
        if (multiBankRefresh_ff)
          refreshBanks_ff <= cmdAddr[15:0];
        else
          refreshBanks_ff <= 16'h0001 << bankNow;
      end
    end
  end

  // data balls drop termination while driving; mask and write clock stay on
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      dqOdtOn_ff <= 1'b0;
      ctlOdtOn_ff <= 1'b0;
    end
    else
    begin
      ctlOdtOn_ff <= odtReqIn && (odtValue_ff != 3'h0);
      dqOdtOn_ff <= odtReqIn && (odtValue_ff != 3'h0) && !readDriving;
    end
  end
endmodule
